// File: rtl/dswp_core.sv
// Purpose: serial write port, 24-bit frames into code and power mode
// Assumes: shift clock much slower than ref_clk_i (160 ns in the bench)
// Notes: pins pass the synchroniser; edges found from its output
`timescale 1ns/1ps
module dswp_core (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // link pins
    input wire logic frame_sel_n_i,
    input wire logic shift_clk_i,
    input wire logic ser_data_i,
    // converter side
    output logic [15:0] dac_code_o,
    output logic power_mode_bit_hi_o,
    output logic power_mode_bit_lo_o,
    output logic update_o,
    output logic abort_o,
    output logic frame_active_o
);
    dswp_pins_if pins ();

    logic sel_n_s;
    logic sclk_s;
    logic din_s;
    logic sel_n_d_r;
    logic sclk_d_r;
    logic sel_fall;
    logic sel_rise;
    logic sclk_fall;
    logic complete;
    logic aborting;
    logic [23:0] sr_r;
    logic [23:0] sr_nxt;
    logic [4:0] cnt_r;
    logic seen_update_r;
    dswp_pkg::dswp_state_t st_r;
    dswp_pkg::dswp_state_t st_nxt;

    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    assign pins.raw = {ser_data_i, shift_clk_i, frame_sel_n_i};

    dswp_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .pins(pins)
    );

    assign sel_n_s = pins.synced[0];
    assign sclk_s = pins.synced[1];
    assign din_s = pins.synced[2];

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_n_d_r <= dswp_pkg::DSWP_SYNC_RESET[0];
            sclk_d_r <= dswp_pkg::DSWP_SYNC_RESET[1];
        end else begin
            sel_n_d_r <= sel_n_s;
            sclk_d_r <= sclk_s;
        end
    end

    assign sel_fall = sel_n_d_r && !sel_n_s;
    assign sel_rise = !sel_n_d_r && sel_n_s;
    assign sclk_fall = sclk_d_r && !sclk_s;

    // a 24th edge coinciding with the select rise still completes
    assign complete = (st_r == dswp_pkg::DSWP_SHIFT) && sclk_fall
        && (cnt_r == dswp_pkg::DSWP_LAST_BIT); // RULE3
    assign aborting = (st_r == dswp_pkg::DSWP_SHIFT) && sel_rise && !complete; // RULE4

    // msb first: new bit enters at the bottom and walks upward
    assign sr_nxt = {sr_r[dswp_pkg::DSWP_FRAME_BITS-2:0], din_s}; // RULE8

    // ------------------------------------------------------------
    // frame state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            dswp_pkg::DSWP_IDLE: begin
                if (sel_fall) begin
                    st_nxt = dswp_pkg::DSWP_SHIFT; // RULE1
                end
            end
            dswp_pkg::DSWP_SHIFT: begin
                if (complete) begin
                    st_nxt = sel_rise ? dswp_pkg::DSWP_IDLE : dswp_pkg::DSWP_DONE;
                end else if (sel_rise) begin
                    st_nxt = dswp_pkg::DSWP_IDLE; // RULE4
                end
            end
            dswp_pkg::DSWP_DONE: begin
                // only a fresh falling select starts the next frame
                if (sel_rise) begin
                    st_nxt = dswp_pkg::DSWP_IDLE; // RULE6
                end
            end
            default: begin
                st_nxt = dswp_pkg::DSWP_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r <= dswp_pkg::DSWP_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // shift register and bit count
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sr_r <= dswp_pkg::DSWP_SR_RESET;
            cnt_r <= dswp_pkg::DSWP_CNT_ZERO;
        end else if (st_r != dswp_pkg::DSWP_SHIFT || aborting) begin
            // partial frame is thrown away
            sr_r <= dswp_pkg::DSWP_SR_RESET; // RULE4
            cnt_r <= dswp_pkg::DSWP_CNT_ZERO;
        end else if (sclk_fall) begin
            sr_r <= sr_nxt; // RULE2
            cnt_r <= cnt_r + dswp_pkg::DSWP_CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // output register and power mode
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dac_code_o <= dswp_pkg::DSWP_MIDSCALE; // RULE7
            power_mode_bit_hi_o <= dswp_pkg::DSWP_MODE_NORMAL;
            power_mode_bit_lo_o <= dswp_pkg::DSWP_MODE_NORMAL;
        end else if (complete) begin
            dac_code_o <= sr_nxt[dswp_pkg::DSWP_CODE_BITS-1:0]; // RULE5
            power_mode_bit_hi_o <= sr_nxt[dswp_pkg::DSWP_MODE_HI_POS]; // RULE5
            power_mode_bit_lo_o <= sr_nxt[dswp_pkg::DSWP_MODE_LO_POS]; // RULE5
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            update_o <= 1'b0;
            abort_o <= 1'b0;
            seen_update_r <= 1'b0;
        end else begin
            update_o <= complete; // RULE3
            abort_o <= aborting; // RULE4
            seen_update_r <= seen_update_r || complete;
        end
    end

    assign frame_active_o = (st_r == dswp_pkg::DSWP_SHIFT);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence last_edge_s;
        st_r == dswp_pkg::DSWP_SHIFT && sclk_fall && cnt_r == dswp_pkg::DSWP_LAST_BIT;
    endsequence

    sequence early_rise_s;
        st_r == dswp_pkg::DSWP_SHIFT && sel_rise && !sclk_fall;
    endsequence

    frame_start_a: assert property ( // RULE1
        (st_r == dswp_pkg::DSWP_IDLE && sel_fall) |=>
        frame_active_o && cnt_r == dswp_pkg::DSWP_CNT_ZERO)
        else $error("frame did not start on select fall");

    bit_shift_a: assert property ( // RULE2
        (frame_active_o && sclk_fall && !sel_rise) |=>
        sr_r == {$past(sr_r[22:0]), $past(din_s)})
        else $error("data bit not shifted on falling edge");

    update_24th_a: assert property ( // RULE3
        last_edge_s |=> update_o ##1 !update_o)
        else $error("update not a single pulse after 24th edge");

    abort_keep_a: assert property ( // RULE4
        early_rise_s |=> abort_o && !update_o && $stable(dac_code_o)
        && $stable(power_mode_bit_lo_o) && $stable(power_mode_bit_hi_o)
        && sr_r == dswp_pkg::DSWP_SR_RESET)
        else $error("abort changed output or kept partial frame");

    code_field_a: assert property ( // RULE5
        last_edge_s |=> dac_code_o == {$past(sr_r[14:0]), $past(din_s)})
        else $error("code field not loaded from low 16 bits");

    no_restart_a: assert property ( // RULE6
        (st_r == dswp_pkg::DSWP_DONE && !sel_rise) |=> !frame_active_o)
        else $error("frame restarted without select rise");

    midscale_hold_a: assert property ( // RULE7
        !seen_update_r |-> dac_code_o == dswp_pkg::DSWP_MIDSCALE
        && !power_mode_bit_hi_o && !power_mode_bit_lo_o)
        else $error("output left midscale before first frame");

    msb_first_a: assert property ( // RULE8
        last_edge_s |=> power_mode_bit_hi_o == $past(sr_r[16])
        && power_mode_bit_lo_o == $past(sr_r[15]))
        else $error("mode bits not taken msb first");
endmodule

// File: rtl/dswp_pkg.sv
// Purpose: constants for the serial write port of a 16-bit converter
// Assumes: one 200 MHz system clock; link pins sampled by it
// Notes: the frame is 24 bits, most significant bit first
//
// Summary of operation
// [RULE1] a frame starts when the host drives frame select low; shifting is then enabled
// [RULE2] each falling shift-clock edge in a frame shifts one data bit into 24 bits
// [RULE3] on the 24th falling edge the output register is updated
// [RULE4] frame select rising before the 24th edge aborts; output and mode stay unchanged
// [RULE5] frame: six ignored bits, two power-mode bits, then sixteen data bits
// [RULE6] host must raise frame select between frames; only its falling edge starts one
// [RULE7] after reset the output holds midscale until the first complete frame
// [RULE8] the first bit sampled ends in the top position of the register
package dswp_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int unsigned DSWP_FRAME_BITS = 24;
    localparam int unsigned DSWP_CODE_BITS = 16;
    localparam int unsigned DSWP_MODE_HI_POS = 17;
    localparam int unsigned DSWP_MODE_LO_POS = 16;
    localparam logic [4:0] DSWP_LAST_BIT = 5'h17;
    localparam logic [4:0] DSWP_CNT_ZERO = 5'h00;
    localparam logic [4:0] DSWP_CNT_ONE = 5'h01;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // two's complement code zero sits at midscale
    localparam logic [15:0] DSWP_MIDSCALE = 16'h0000;
    localparam logic DSWP_MODE_NORMAL = 1'b0;
    localparam logic [23:0] DSWP_SR_RESET = 24'h000000;
    // frame select idles high, so its synchroniser resets high
    localparam logic [2:0] DSWP_SYNC_RESET = 3'h1;

    // ------------------------------------------------------------
    // frame state, one-hot
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DSWP_IDLE = 3'b001,
        DSWP_SHIFT = 3'b010,
        DSWP_DONE = 3'b100
    } dswp_state_t;
endpackage

// File: rtl/dswp_pins_if.sv
// Purpose: carries the link pins into and out of the synchroniser
// Assumes: synced is on ref_clk_i; raw carries the asynchronous pins
// Notes: bit 0 frame select (low active), bit 1 shift clock, bit 2 data
`timescale 1ns/1ps
interface dswp_pins_if;
    logic [2:0] raw;
    logic [2:0] synced;
    modport sync_side (input raw, output synced);
    modport core_side (output raw, input synced);
endinterface

// File: rtl/dswp_sync.sv
// Purpose: two flip-flop synchroniser for the link pins
// Assumes: pins are asynchronous to ref_clk_i
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module dswp_sync (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // pins
    dswp_pins_if.sync_side pins
);
    logic [2:0] meta_r;
    logic [2:0] stable_r;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= dswp_pkg::DSWP_SYNC_RESET;
            stable_r <= dswp_pkg::DSWP_SYNC_RESET;
        end else begin
            meta_r <= pins.raw;
            stable_r <= meta_r;
        end
    end

    assign pins.synced = stable_r;
endmodule

// File: sim/dswp_host_model.sv
// Purpose: host side of the serial write port, drives select, shift clock and data
// Assumes: pins change only at falling edges of ref_clk_i
// Notes: shift clock 160 ns, idles high; data inverted after the last bit
`timescale 1ns/1ps
module dswp_host_model (
    // clock
    input wire logic ref_clk_i,
    // link pins
    output logic frame_sel_n_o,
    output logic shift_clk_o,
    output logic ser_data_o
);
    initial begin
        frame_sel_n_o = 1'b1;
        shift_clk_o = 1'b1;
        ser_data_o = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // one 32-cycle shift-clock period, low for the middle 16 cycles
    task automatic pulse(input logic b);
        ser_data_o = b;
        wt(8);
        shift_clk_o = 1'b0;
        wt(16);
        shift_clk_o = 1'b1;
        wt(8);
    endtask
    task automatic send(input logic [23:0] w, input int n, input bit hold, input int extra);
        if (frame_sel_n_o == 1'b0) begin
            frame_sel_n_o = 1'b1;
            wt(8);
        end
        frame_sel_n_o = 1'b0;
        wt(8);
        for (int i = 0; i < n; i++) pulse(w[23 - i]);
        for (int i = 0; i < extra; i++) pulse(~ser_data_o);
        ser_data_o = ~ser_data_o;
        wt(8);
        if (!hold) frame_sel_n_o = 1'b1;
        wt(8);
    endtask
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) pulse(~ser_data_o);
    endtask
endmodule

// File: sim/tb_dac_serial_write_port.sv
// Purpose: self-checking bench for the serial write port core
// Assumes: host model drives the pins; bench inputs change on falling edges
// Notes: pulse counters catch missing, extra and stretched strobes
`timescale 1ns/1ps
module tb_dac_serial_write_port;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    wire logic fs_n;
    wire logic sck;
    wire logic sd;
    logic [15:0] code;
    logic m_hi;
    logic m_lo;
    logic upd;
    logic abt;
    logic act;
    int error_cnt = 0;
    int total_checks = 0;
    int upd_cnt = 0;
    int abt_cnt = 0;
    int act_cnt = 0;
    logic act_d = 1'b0;
    logic [17:0] exp_out = {2'b00, dswp_pkg::DSWP_MIDSCALE};

    always #2.5 ref_clk_i = ~ref_clk_i;

    dswp_host_model host (.ref_clk_i(ref_clk_i), .frame_sel_n_o(fs_n), .shift_clk_o(sck),
        .ser_data_o(sd));
    dswp_core dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .frame_sel_n_i(fs_n),
        .shift_clk_i(sck), .ser_data_i(sd), .dac_code_o(code), .power_mode_bit_hi_o(m_hi),
        .power_mode_bit_lo_o(m_lo), .update_o(upd), .abort_o(abt), .frame_active_o(act));

    always @(posedge ref_clk_i) begin
        if (upd === 1'b1) upd_cnt++;
        if (abt === 1'b1) abt_cnt++;
        // counts frame starts seen on the active flag
        if (act === 1'b1 && act_d !== 1'b1) act_cnt++;
        act_d = act;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // sends one frame and judges strobes and outputs afterwards
    task automatic frame(input logic [23:0] w, input int n, input bit hold, input int extra);
        int u;
        int a;
        int r;
        u = upd_cnt;
        a = abt_cnt;
        r = act_cnt;
        host.send(w, n, hold, extra);
        repeat (12) @(negedge ref_clk_i);
        if (n == 24) exp_out = w[17:0];
        chk(upd_cnt - u, (n == 24) ? 1 : 0);
        chk(abt_cnt - a, (n < 24) ? 1 : 0);
        chk({m_hi, m_lo, code}, exp_out);
        chk(act, 1'b0);
        chk(act_cnt - r, 1);
    endtask

    task automatic t_reset;
        chk({m_hi, m_lo, code}, exp_out);
        chk({upd, abt, act}, 3'h0);
    endtask

    task automatic t_idle;
        host.idle_clocks(4);
        repeat (8) @(negedge ref_clk_i);
        chk({upd_cnt[7:0], abt_cnt[7:0]}, 16'h0000);
        chk({m_hi, m_lo, code}, exp_out);
    endtask

    task automatic t_modes;
        logic [15:0] codes [4] = '{16'h8000, 16'h7FFF, 16'hA55A, 16'h0001};
        for (int m = 0; m < 4; m++) frame({6'h2A, m[1:0], codes[m]}, 24, 0, 0);
    endtask

    task automatic t_abort;
        frame(24'hFFFFFF, 23, 0, 0);
        frame(24'hC00000, 1, 0, 0);
    endtask

    task automatic t_hold_low;
        frame(24'h011234, 24, 1, 3);
        chk(fs_n, 1'b0);
        frame(24'h02C3C3, 24, 0, 0);
    endtask

    // watchdog: the whole run needs about 30 us
    initial begin
        #300us;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (6) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        t_reset();
        t_idle();
        t_modes();
        t_abort();
        t_hold_low();
        summarize();
    end
endmodule
